// File: inc/mfc_pkg.sv
// What this block does
// R1: Write select 00 holds all coefficients; 01, 10, 11 load set 1, 2, 3.
// R2: Matrix mode uses all three inputs and outputs; sums truncate to 12-bit integers.
// R3: Matrix outputs one, two, three use coefficient sets one, two, three.
// R4: Matrix result appears five cycles after its data; one result per cycle.
// R5: FIR mode takes the first and second data inputs plus cascade input.
// R6: Upstream presents each FIR sample on both data inputs together.
// R7: Filter cascade output is half-LSB rounded to 16 bits, one per cycle.
// R8: FIR impulse gives nine output samples, from cycle five to cycle thirteen.
// R9: FIR centre tap response appears nine cycles after the impulse.
// R10: FIR cascade input reaches cascade output four cycles later.
// R11: FIR output sums three tap groups per the latency equation plus cascade.
// R12: 3x3 convolver sums the last nine pixel products plus cascade each cycle.
// R13: 3x3 convolver weights each port's three samples by its own three sets.
// R14: 4x2 convolver uses first and second inputs, adds cascade, rounds to 16.
// R15: 4x2 convolver oldest samples use third-port sets three and one.
// R16: Registered operating select sets the mode for data entering next cycle.
// R17: Coefficients are 10-bit fractional, data 12-bit integer, two's complement.
// R18: Filter modes form cascade in and out from result pins plus four bits.
// R19: Coefficient ports are captured into the selected set at the next edge.
// R20: Upstream treats outputs as invalid until the pipeline has flushed.
package mfc_pkg;
    localparam int DATA_W = 12;
    localparam int COEF_W = 10;
    localparam int CASC_W = 16;
    localparam int SUM_W = 26;
    localparam int PROD_FRAC = 9;
    localparam int CASC_FRAC = 4;
    localparam int NUM_PORTS = 3;
    localparam int NUM_SETS = 3;
    // History taps, counted in edges back from the edge that writes the output
    localparam int TAP_NEW = 3;
    localparam int TAP_CASC = 2;
    localparam int A_DEPTH = 7;
    localparam int B_DEPTH = 12;
    localparam int C_DEPTH = 6;
    localparam int CASC_DEPTH = 3;
    localparam int BUF_DEPTH = 2;
    localparam logic signed [SUM_W-1:0] ROUND_HALF = 26'h000_0010;
    localparam logic [1:0] CSEL_HOLD = 2'h0;
    localparam logic [1:0] CSEL_SET1 = 2'h1;
    localparam logic [1:0] CSEL_SET2 = 2'h2;
    localparam logic [1:0] CSEL_SET3 = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
    localparam logic [COEF_W-1:0] COEF_RESET = 10'h000;
    localparam logic [CASC_W-1:0] CASC_RESET = 16'h0000;

    typedef enum logic [1:0] {MODE_MATRIX, MODE_FIR, MODE_CONV3, MODE_CONV4} mode_t;

    typedef struct packed {
        logic valid;
        mode_t mode;
    } tag_t;

    typedef struct packed {
        logic [DATA_W-1:0] x;
        logic [DATA_W-1:0] y;
        logic [DATA_W-1:0] z;
    } out_word_t;
endpackage

// File: design/matrix_fir_convolver.sv
`timescale 1ns/1ps
module matrix_fir_convolver #(
    parameter int BUF_DEPTH = mfc_pkg::BUF_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic [1:0] op_select_i,
    input wire logic [1:0] coef_set_write_sel_i,
    // Coefficient ports
    input wire logic [mfc_pkg::COEF_W-1:0] coef_port_first_i,
    input wire logic [mfc_pkg::COEF_W-1:0] coef_port_second_i,
    input wire logic [mfc_pkg::COEF_W-1:0] coef_port_third_i,
    // Data inputs and input handshake
    input wire logic [mfc_pkg::DATA_W-1:0] data_first_i,
    input wire logic [mfc_pkg::DATA_W-1:0] data_second_i,
    input wire logic [mfc_pkg::DATA_W-1:0] data_third_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // Two-way result and cascade pins
    input wire logic [mfc_pkg::DATA_W-1:0] result_first_or_cascade_pins_i,
    output logic [mfc_pkg::DATA_W-1:0] result_first_or_cascade_pins_o,
    output logic result_first_or_cascade_pins_oe_o,
    input wire logic [3:0] result_second_cascade_pins_i,
    output logic [3:0] result_second_cascade_pins_o,
    output logic result_second_cascade_pins_oe_o,
    // Output-only result pins and output handshake
    output logic [7:0] result_second_low_o,
    output logic [mfc_pkg::DATA_W-1:0] result_third_or_cascade_pins_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CNT_W = $clog2(BUF_DEPTH + 1);

    typedef logic signed [mfc_pkg::SUM_W-1:0] sum_t;

    logic [mfc_pkg::COEF_W-1:0] coef_q [mfc_pkg::NUM_PORTS][mfc_pkg::NUM_SETS];
    logic [mfc_pkg::DATA_W-1:0] a_h [mfc_pkg::A_DEPTH];
    logic [mfc_pkg::DATA_W-1:0] b_h [mfc_pkg::B_DEPTH];
    logic [mfc_pkg::DATA_W-1:0] c_h [mfc_pkg::C_DEPTH];
    logic [mfc_pkg::CASC_W-1:0] casc_h [mfc_pkg::CASC_DEPTH];
    mfc_pkg::tag_t tag_h [mfc_pkg::A_DEPTH];
    mfc_pkg::mode_t mode_q;
    mfc_pkg::out_word_t buf_q [BUF_DEPTH];
    mfc_pkg::out_word_t word_d;
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic [mfc_pkg::CASC_W-1:0] cascade_in;
    logic [mfc_pkg::CASC_W-1:0] cascade_out;
    logic advance;
    logic push;
    logic pop;
    logic full;
    sum_t sum_x;
    sum_t sum_y;
    sum_t sum_z;
    sum_t sum_f;
    sum_t casc_term;

    // Signed 12 x 10 product, nine fractional bits, widened to the sum width
    function automatic sum_t mac(input logic [mfc_pkg::DATA_W-1:0] d, input logic [mfc_pkg::COEF_W-1:0] k);
        logic signed [mfc_pkg::DATA_W+mfc_pkg::COEF_W-1:0] p;
        p = $signed(d) * $signed(k); // [R17]
        mac = sum_t'(p);
    endfunction

    // The whole pipeline holds while the buffer cannot take a word, so nothing is lost
    assign full = (count_q == CNT_W'(BUF_DEPTH));
    assign pop = out_valid_o && out_ready_i;
    assign advance = !full || out_ready_i;
    assign in_ready_o = advance;
    assign push = advance && tag_h[mfc_pkg::TAP_NEW].valid;
    assign out_valid_o = (count_q != '0);

    assign cascade_in = {result_first_or_cascade_pins_i, result_second_cascade_pins_i}; // [R18]

    // Later samples are summed in a new mode; words already in flight keep their tagged mode, but the pin direction follows mode_q at once
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            mode_q <= mfc_pkg::MODE_MATRIX;
        else
            mode_q <= mfc_pkg::mode_t'(op_select_i); // [R16]
    end

    // Coefficient store
    // Loads are not held back by a stall, so a write lands even while the pipeline waits
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int p = 0; p < mfc_pkg::NUM_PORTS; p++)
                for (int s = 0; s < mfc_pkg::NUM_SETS; s++)
                    coef_q[p][s] <= mfc_pkg::COEF_RESET;
        end
        else if (coef_set_write_sel_i != mfc_pkg::CSEL_HOLD) // [R1]
        begin
            coef_q[0][coef_set_write_sel_i - 2'h1] <= coef_port_first_i; // [R19]
            coef_q[1][coef_set_write_sel_i - 2'h1] <= coef_port_second_i;
            coef_q[2][coef_set_write_sel_i - 2'h1] <= coef_port_third_i;
        end
    end

    // Sample histories; taps shift only when the pipeline advances
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            for (int i = 0; i < mfc_pkg::A_DEPTH; i++)
            begin
                a_h[i] <= mfc_pkg::DATA_RESET;
                tag_h[i] <= '{valid: 1'b0, mode: mfc_pkg::MODE_MATRIX};
            end
            for (int i = 0; i < mfc_pkg::B_DEPTH; i++)
                b_h[i] <= mfc_pkg::DATA_RESET;
            for (int i = 0; i < mfc_pkg::C_DEPTH; i++)
                c_h[i] <= mfc_pkg::DATA_RESET;
            for (int i = 0; i < mfc_pkg::CASC_DEPTH; i++)
                casc_h[i] <= mfc_pkg::CASC_RESET;
        end
        else if (advance)
        begin
            a_h[0] <= data_first_i;
            b_h[0] <= data_second_i; // [R5]
            c_h[0] <= data_third_i;
            casc_h[0] <= cascade_in;
            tag_h[0] <= '{valid: in_valid_i, mode: mode_q}; // [R16]
            for (int i = 1; i < mfc_pkg::A_DEPTH; i++)
            begin
                a_h[i] <= a_h[i-1];
                tag_h[i] <= tag_h[i-1];
            end
            for (int i = 1; i < mfc_pkg::B_DEPTH; i++)
                b_h[i] <= b_h[i-1];
            for (int i = 1; i < mfc_pkg::C_DEPTH; i++)
                c_h[i] <= c_h[i-1];
            for (int i = 1; i < mfc_pkg::CASC_DEPTH; i++)
                casc_h[i] <= casc_h[i-1];
        end
    end

    // Sums of products; taps 3..5 are the newest three columns in every filter mode, matrix mode uses tap 3 only
    always_comb
    begin
        casc_term = sum_t'($signed(casc_h[mfc_pkg::TAP_CASC])) <<< (mfc_pkg::PROD_FRAC - mfc_pkg::CASC_FRAC); // [R10]
        sum_x = mac(a_h[3], coef_q[0][0]) + mac(b_h[3], coef_q[1][0]) + mac(c_h[3], coef_q[2][0]); // [R3]
        sum_y = mac(a_h[3], coef_q[0][1]) + mac(b_h[3], coef_q[1][1]) + mac(c_h[3], coef_q[2][1]);
        sum_z = mac(a_h[3], coef_q[0][2]) + mac(b_h[3], coef_q[1][2]) + mac(c_h[3], coef_q[2][2]);
        sum_f = casc_term;
        unique case (tag_h[mfc_pkg::TAP_NEW].mode)
            mfc_pkg::MODE_MATRIX:
                sum_f = casc_term;
            mfc_pkg::MODE_FIR:
                // Second port feeds the older six of the nine taps; its older three use the third port's sets
                sum_f = casc_term + mac(a_h[3], coef_q[0][2]) + mac(a_h[4], coef_q[0][1]) // [R11]
                    + mac(a_h[5], coef_q[0][0]) + mac(b_h[6], coef_q[1][2]) + mac(b_h[7], coef_q[1][1])
                    + mac(b_h[8], coef_q[1][0]) + mac(b_h[9], coef_q[2][2]) + mac(b_h[10], coef_q[2][1])
                    + mac(b_h[11], coef_q[2][0]); // [R8] [R9]
            mfc_pkg::MODE_CONV3:
                sum_f = casc_term + mac(a_h[3], coef_q[0][2]) + mac(a_h[4], coef_q[0][1]) // [R13]
                    + mac(a_h[5], coef_q[0][0]) + mac(b_h[3], coef_q[1][2]) + mac(b_h[4], coef_q[1][1])
                    + mac(b_h[5], coef_q[1][0]) + mac(c_h[3], coef_q[2][2]) + mac(c_h[4], coef_q[2][1])
                    + mac(c_h[5], coef_q[2][0]); // [R12]
            mfc_pkg::MODE_CONV4:
                sum_f = casc_term + mac(a_h[3], coef_q[0][2]) + mac(a_h[4], coef_q[0][1]) // [R15]
                    + mac(a_h[5], coef_q[0][0]) + mac(a_h[6], coef_q[2][2]) + mac(b_h[3], coef_q[1][2])
                    + mac(b_h[4], coef_q[1][1]) + mac(b_h[5], coef_q[1][0])
                    + mac(b_h[6], coef_q[2][0]); // [R14]
        endcase
    end

    // Output formatting: matrix truncates, filters round by half an LSB
    always_comb
    begin
        cascade_out = 16'(sum_f + mfc_pkg::ROUND_HALF >>> (mfc_pkg::PROD_FRAC - mfc_pkg::CASC_FRAC)); // [R7]
        if (tag_h[mfc_pkg::TAP_NEW].mode == mfc_pkg::MODE_MATRIX)
        begin
            word_d.x = 12'(sum_x >>> mfc_pkg::PROD_FRAC); // [R2]
            word_d.y = 12'(sum_y >>> mfc_pkg::PROD_FRAC);
            word_d.z = 12'(sum_z >>> mfc_pkg::PROD_FRAC);
        end
        else
        begin
            word_d.x = '0;
            word_d.y = {8'h00, cascade_out[3:0]}; // [R18]
            word_d.z = cascade_out[15:4];
        end
    end

    // Two-entry output buffer; its head register drives the pins
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            for (int i = 0; i < BUF_DEPTH; i++)
                buf_q[i] <= '0;
        end
        else
        begin
            if (push)
            begin
                buf_q[wr_ptr_q] <= word_d; // [R4]
                wr_ptr_q <= (wr_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
                rd_ptr_q <= (rd_ptr_q == PTR_W'(BUF_DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end

    // The result-one pins turn round to cascade input in the filter modes
    assign result_first_or_cascade_pins_oe_o = (mode_q == mfc_pkg::MODE_MATRIX); // [R18]
    assign result_second_cascade_pins_oe_o = (mode_q == mfc_pkg::MODE_MATRIX);
    assign result_first_or_cascade_pins_o = buf_q[rd_ptr_q].x;
    assign result_second_cascade_pins_o = buf_q[rd_ptr_q].y[11:8];
    assign result_second_low_o = buf_q[rd_ptr_q].y[7:0];
    assign result_third_or_cascade_pins_o = buf_q[rd_ptr_q].z;

    property p_coef_hold;
        @(posedge clk_i) disable iff (reset_i)
        coef_set_write_sel_i == mfc_pkg::CSEL_HOLD |=> $stable(coef_q[0][0]) && $stable(coef_q[1][1]);
    endproperty
    a_coef_hold: assert property (p_coef_hold) else $error("Coefficient changed on hold select"); // [R1]

    property p_coef_load;
        @(posedge clk_i) disable iff (reset_i)
        coef_set_write_sel_i == mfc_pkg::CSEL_SET2
        |=> coef_q[0][1] == $past(coef_port_first_i) && coef_q[2][1] == $past(coef_port_third_i);
    endproperty
    a_coef_load: assert property (p_coef_load) else $error("Set 2 not loaded from ports"); // [R19]

    property p_mode_reg;
        @(posedge clk_i) disable iff (reset_i)
        1'b1 |=> mode_q == mfc_pkg::mode_t'($past(op_select_i));
    endproperty
    a_mode_reg: assert property (p_mode_reg) else $error("Mode not registered from select"); // [R16]

    property p_matrix_lat;
        @(posedge clk_i) disable iff (reset_i)
        (in_valid_i && in_ready_o && mode_q == mfc_pkg::MODE_MATRIX) ##1 in_ready_o [*4]
        |-> push && tag_h[mfc_pkg::TAP_NEW].mode == mfc_pkg::MODE_MATRIX;
    endproperty
    a_matrix_lat: assert property (p_matrix_lat) else $error("Matrix result not written on time"); // [R4]

    property p_matrix_trunc;
        @(posedge clk_i) disable iff (reset_i)
        push && tag_h[mfc_pkg::TAP_NEW].mode == mfc_pkg::MODE_MATRIX
        ##1 (count_q == 2'd1 && out_valid_o)
        |-> result_third_or_cascade_pins_o == $past(sum_z[20:9]);
    endproperty
    a_matrix_trunc: assert property (p_matrix_trunc) else $error("Matrix output not truncated sum"); // [R2]

    property p_casc_path;
        @(posedge clk_i) disable iff (reset_i)
        advance ##1 advance ##1 advance |=> casc_h[mfc_pkg::TAP_CASC] == $past(cascade_in, 3);
    endproperty
    a_casc_path: assert property (p_casc_path) else $error("Cascade input tap misaligned"); // [R10]

    property p_fir_round;
        @(posedge clk_i) disable iff (reset_i)
        push && tag_h[mfc_pkg::TAP_NEW].mode != mfc_pkg::MODE_MATRIX && count_q == '0
        |=> {result_third_or_cascade_pins_o, result_second_low_o[3:0]} == $past(16'((sum_f + 26'sh000_0010) >>> 5));
    endproperty
    a_fir_round: assert property (p_fir_round) else $error("Cascade output not half-LSB rounded"); // [R7]

    property p_oe_mode;
        @(posedge clk_i) disable iff (reset_i)
        ##1 result_first_or_cascade_pins_oe_o == ($past(op_select_i) == 2'h0);
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("Result pins driven in filter mode"); // [R18]

    property p_buf_hold;
        @(posedge clk_i) disable iff (reset_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(result_third_or_cascade_pins_o);
    endproperty
    a_buf_hold: assert property (p_buf_hold) else $error("Stalled output word changed");

    property p_buf_count;
        @(posedge clk_i) disable iff (reset_i)
        push && !pop |=> count_q == $past(count_q) + 1'b1;
    endproperty
    a_buf_count: assert property (p_buf_count) else $error("Buffer lost a pushed word");


    // Scenarios worth seeing: each filter mode, a full buffer and a mode change
    c_fir_run: cover property (@(posedge clk_i) disable iff (reset_i)
        push && tag_h[mfc_pkg::TAP_NEW].mode == mfc_pkg::MODE_FIR [*4]);
    c_conv4_out: cover property (@(posedge clk_i) disable iff (reset_i)
        push && tag_h[mfc_pkg::TAP_NEW].mode == mfc_pkg::MODE_CONV4);
    c_buf_full: cover property (@(posedge clk_i) disable iff (reset_i) full ##1 pop);
    c_conv3_out: cover property (@(posedge clk_i) disable iff (reset_i)
        push && tag_h[mfc_pkg::TAP_NEW].mode == mfc_pkg::MODE_CONV3);
    c_mode_switch: cover property (@(posedge clk_i) disable iff (reset_i)
        mode_q != mfc_pkg::mode_t'(op_select_i));
endmodule

// File: dv/mfc_far_end.sv
`timescale 1ns/1ps
module mfc_far_end (
    // Clock and stall request
    input wire logic clk_i,
    input wire logic stall_i,
    // Cascade value and design pin drive
    input wire logic [15:0] cascade_i,
    input wire logic [11:0] x_i,
    input wire logic [3:0] y_i,
    input wire logic x_oe_i,
    input wire logic y_oe_i,
    // Resolved pins and consumer ready
    output logic [11:0] x_wire_o,
    output logic [3:0] y_wire_o,
    output logic out_ready_o
);
    logic [2:0] cnt_q = 3'h0;
    always_ff @(posedge clk_i)
    begin
        cnt_q <= cnt_q + 3'h1;
    end
    // While stalled, ready one cycle in eight, so the buffer really fills
    assign out_ready_o = !stall_i || (cnt_q == 3'h7);
    // Cascade only while the design lets go of the pins
    assign x_wire_o = x_oe_i ? x_i : cascade_i[15:4];
    assign y_wire_o = y_oe_i ? y_i : cascade_i[3:0];
endmodule

// File: dv/matrix_fir_convolver_test.sv
`timescale 1ns/1ps
module matrix_fir_convolver_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] op = 2'h0;
    logic [1:0] csel = 2'h0;
    logic [9:0] kp [3] = '{default: 10'h000};
    logic [11:0] d [3] = '{default: 12'h000};
    logic iv = 1'b0;
    logic stall = 1'b0;
    logic [15:0] casc = 16'h0000;
    logic ir, ov, ordy, xoe, yoe, ir_s, saw_full;
    logic [11:0] x_w, x_o, z_o;
    logic [3:0] y_w, y_o;
    logic [7:0] ylo;
    logic signed [11:0] h [3][4096];
    logic [15:0] hc [4096];
    logic signed [9:0] k [3][3] = '{default: 10'h000};
    logic [1:0] cur_m = 2'h0;
    int pend [$];
    int nh = 0;
    int cyc = 0;
    int n_mismatch = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    matrix_fir_convolver matrix_fir_convolver_inst (
        .clk_i(clk), .reset_i(reset), .op_select_i(op), .coef_set_write_sel_i(csel),
        .coef_port_first_i(kp[0]), .coef_port_second_i(kp[1]), .coef_port_third_i(kp[2]),
        .data_first_i(d[0]), .data_second_i(d[1]), .data_third_i(d[2]),
        .in_valid_i(iv), .in_ready_o(ir),
        .result_first_or_cascade_pins_i(x_w), .result_first_or_cascade_pins_o(x_o),
        .result_first_or_cascade_pins_oe_o(xoe), .result_second_cascade_pins_i(y_w),
        .result_second_cascade_pins_o(y_o), .result_second_cascade_pins_oe_o(yoe),
        .result_second_low_o(ylo), .result_third_or_cascade_pins_o(z_o),
        .out_valid_o(ov), .out_ready_i(ordy));

    mfc_far_end mfc_far_end_inst (
        .clk_i(clk), .stall_i(stall), .cascade_i(casc), .x_i(x_o), .y_i(y_o),
        .x_oe_i(xoe), .y_oe_i(yoe), .x_wire_o(x_w), .y_wire_o(y_w), .out_ready_o(ordy));

    task automatic print_verdict();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp_word(input string name, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_flag(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    function automatic logic [35:0] expect_word(input int j);
        logic signed [25:0] s [3];
        logic [15:0] c;
        s = '{default: 26'h000_0000};
        c = hc[j + 1];
        for (int i = 0; i < 3; i++)
        begin
            case (cur_m)
                2'h0: s[i] = h[0][j] * k[0][i] + h[1][j] * k[1][i] + h[2][j] * k[2][i];
                2'h1: s[0] += h[0][j-i] * k[0][2-i] + h[1][j-3-i] * k[1][2-i] + h[1][j-6-i] * k[2][2-i];
                2'h2: s[0] += h[0][j-i] * k[0][2-i] + h[1][j-i] * k[1][2-i] + h[2][j-i] * k[2][2-i];
                default: s[0] += h[0][j-i] * k[0][2-i] + h[1][j-i] * k[1][2-i];
            endcase
        end
        if (cur_m == 2'h3)
            s[0] += h[0][j-3] * k[2][2] + h[1][j-3] * k[2][0];
        if (cur_m == 2'h0)
            return {s[0][20:9], s[1][20:9], s[2][20:9]};
        s[0] += {{5{c[15]}}, c, 5'h00} + 26'h000_0010;
        return {20'h0_0000, s[0][20:5]};
    endfunction

    function automatic logic [11:0] dv(input int p, input int i);
        if (i == 1)
            return 12'h7ff;
        if (i == 2)
            return 12'h800;
        return 12'(i * 12'h1a5 + p * 12'h3c7 + 12'h801);
    endfunction

    // Samples shift in on every ready edge, so history follows edges, not calls
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        casc <= casc + 16'h0731;
        if (!reset && ir_s === 1'b1)
        begin
            for (int p = 0; p < 3; p++)
                h[p][nh] = d[p];
            hc[nh] = casc;
            if (iv === 1'b1)
                pend.push_back(nh);
            nh++;
        end
        if (cyc == 4000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    always @(negedge clk)
    begin
        ir_s = ir;
        if (ir === 1'b0)
            saw_full = 1'b1;
        if (!reset && ov === 1'b1 && ordy === 1'b1)
            cmp_word("output_word", pend.size() > 0 ? expect_word(pend.pop_front()) : {36{1'bx}},
                cur_m == 2'h0 ? {x_o, y_o, ylo, z_o} : {16'h0000, ylo[7:4], z_o, ylo[3:0]});
    end

    task automatic put(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c, input logic v);
        d[0] <= a;
        d[1] <= b;
        d[2] <= c;
        iv <= v;
        do @(posedge clk); while (ir_s !== 1'b1);
    endtask

    task automatic load(input logic [1:0] sel, input logic [9:0] a, input logic [9:0] b, input logic [9:0] c);
        csel <= sel;
        kp[0] <= a;
        kp[1] <= b;
        kp[2] <= c;
        @(posedge clk);
        if (sel != 2'h0)
        begin
            k[0][sel - 2'h1] = a;
            k[1][sel - 2'h1] = b;
            k[2][sel - 2'h1] = c;
        end
    endtask

    task automatic drain();
        repeat (200) if (pend.size() != 0) @(negedge clk);
        repeat (8) @(negedge clk);
        cmp_word("pending_words", 36'h0_0000_0000, 36'(pend.size()));
        cmp_flag("out_valid_idle", 1'b0, ov);
        // Hand back on a rising edge, so that the next drive lands there
        @(posedge clk);
    endtask

    task automatic flush(input logic [1:0] m);
        drain();
        op <= m;
        cur_m = m;
        repeat (13) put(12'h000, 12'h000, 12'h000, 1'b0);
    endtask

    task automatic stream(input int n, input bit same_ab, input bit imp);
        logic [11:0] a;
        for (int i = 0; i < n; i++)
        begin
            a = imp ? (i == 0 ? 12'h100 : 12'h000) : dv(0, i);
            put(a, same_ab ? a : dv(1, i), dv(2, i), 1'b1);
        end
        put(12'h000, 12'h000, 12'h000, 1'b0);
        drain();
    endtask

    task automatic t_reset();
        @(negedge clk);
        cmp_flag("out_valid_reset", 1'b0, ov);
        cmp_flag("in_ready_reset", 1'b1, ir);
        cmp_flag("x_oe_reset", 1'b1, xoe);
        @(posedge clk);
        reset <= 1'b0;
    endtask

    task automatic t_coef();
        load(2'h1, 10'h1ff, 10'h200, 10'h0a3);
        load(2'h2, 10'h155, 10'h3c1, 10'h07f);
        load(2'h3, 10'h2aa, 10'h040, 10'h301);
        load(2'h0, 10'h111, 10'h222, 10'h333);
    endtask

    task automatic t_stall();
        saw_full = 1'b0;
        stall <= 1'b1;
        stream(12, 1'b0, 1'b0);
        cmp_flag("buffer_refused", 1'b1, saw_full);
        stall <= 1'b0;
    endtask

    task automatic t_latency(input logic [1:0] m);
        int t;
        flush(m);
        put(12'h123, 12'h123, 12'h456, 1'b1);
        t = cyc;
        put(12'h000, 12'h000, 12'h000, 1'b0);
        @(negedge clk);
        repeat (20) if (ov !== 1'b1) @(negedge clk);
        cmp_word("latency", 36'h0_0000_0005, 36'(cyc - t));
        drain();
    endtask

    initial
    begin
        repeat (15) @(posedge clk);
        t_reset();
        t_coef();
        cmp_flag("x_oe_matrix", 1'b1, xoe);
        stream(20, 1'b0, 1'b0);
        t_stall();
        flush(2'h1);
        cmp_flag("y_oe_filter", 1'b0, yoe);
        stream(12, 1'b1, 1'b1);
        stream(20, 1'b1, 1'b0);
        flush(2'h2);
        stream(16, 1'b0, 1'b0);
        flush(2'h3);
        stream(16, 1'b0, 1'b0);
        for (int m = 0; m < 4; m++)
            t_latency(2'(m));
        print_verdict();
    end
endmodule
